/* File: src/ccr_pkg.sv */
// Purpose: Shared constants and carrier types for the converter configuration register bank.
// Assumes: Serial pins are synchronous to ref_clk; frames are 8 address bits then 8 data bits, MSB first.
// Notes:   Register addresses are the printed serial addresses.
package ccr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int unsigned CCR_NUM_REGS = 11;

  localparam logic [7:0] CCR_ADDR_CTRL      = 8'h00;
  localparam logic [7:0] CCR_ADDR_SWING     = 8'h01;
  localparam logic [7:0] CCR_ADDR_PERF_ONE  = 8'h03;
  localparam logic [7:0] CCR_ADDR_GAIN_TEST = 8'h25;
  localparam logic [7:0] CCR_ADDR_DRIVE     = 8'h26;
  localparam logic [7:0] CCR_ADDR_FORMAT    = 8'h3D;
  localparam logic [7:0] CCR_ADDR_CUST_HIGH = 8'h3F;
  localparam logic [7:0] CCR_ADDR_CUST_LOW  = 8'h40;
  localparam logic [7:0] CCR_ADDR_IFACE     = 8'h41;
  localparam logic [7:0] CCR_ADDR_SWING_EN  = 8'h43;
  localparam logic [7:0] CCR_ADDR_PERF_TWO  = 8'h4A;

  // Index order of the storage array.
  localparam logic [CCR_NUM_REGS-1:0][7:0] CCR_ADDR_LIST = {
    CCR_ADDR_PERF_TWO, CCR_ADDR_SWING_EN, CCR_ADDR_IFACE, CCR_ADDR_CUST_LOW,
    CCR_ADDR_CUST_HIGH, CCR_ADDR_FORMAT, CCR_ADDR_DRIVE, CCR_ADDR_GAIN_TEST,
    CCR_ADDR_PERF_ONE, CCR_ADDR_SWING, CCR_ADDR_CTRL};

  localparam logic [CCR_NUM_REGS-1:0][7:0] CCR_RESET_LIST = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h00, 8'h00, 8'h00};

  // Writable bits; reserved bits are never stored and read back as zero.
  localparam logic [CCR_NUM_REGS-1:0][7:0] CCR_WMASK_LIST = {
    8'h01, 8'h03, 8'hFF, 8'hFF, 8'h3F, 8'hE0, 8'h03, 8'hF7, 8'h03, 8'hFC, 8'h01};

  localparam int unsigned CCR_IDX_CTRL      = 0;
  localparam int unsigned CCR_IDX_SWING     = 1;
  localparam int unsigned CCR_IDX_PERF_ONE  = 2;
  localparam int unsigned CCR_IDX_GAIN_TEST = 3;
  localparam int unsigned CCR_IDX_DRIVE     = 4;
  localparam int unsigned CCR_IDX_FORMAT    = 5;
  localparam int unsigned CCR_IDX_CUST_HIGH = 6;
  localparam int unsigned CCR_IDX_CUST_LOW  = 7;
  localparam int unsigned CCR_IDX_IFACE     = 8;
  localparam int unsigned CCR_IDX_SWING_EN  = 9;
  localparam int unsigned CCR_IDX_PERF_TWO  = 10;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned CCR_BIT_READBACK   = 0;
  localparam int unsigned CCR_BIT_SOFT_RESET = 1;
  localparam int unsigned CCR_SWING_MSB      = 7;
  localparam int unsigned CCR_SWING_LSB      = 2;
  localparam int unsigned CCR_GAIN_MSB       = 7;
  localparam int unsigned CCR_GAIN_LSB       = 4;
  localparam int unsigned CCR_TEST_MSB       = 2;
  localparam int unsigned CCR_TEST_LSB       = 0;
  localparam int unsigned CCR_BIT_CLK_BOOST  = 1;
  localparam int unsigned CCR_BIT_DATA_BOOST = 0;
  localparam int unsigned CCR_FMT_MSB        = 7;
  localparam int unsigned CCR_FMT_LSB        = 6;
  localparam int unsigned CCR_BIT_OFFSET_EN  = 5;
  localparam int unsigned CCR_CUST_HIGH_MSB  = 5;
  localparam int unsigned CCR_IF_MSB         = 7;
  localparam int unsigned CCR_IF_LSB         = 6;
  localparam int unsigned CCR_SE_DRIVE_MSB   = 5;
  localparam int unsigned CCR_SE_DRIVE_LSB   = 4;
  localparam int unsigned CCR_BIT_RISE_EN    = 3;
  localparam int unsigned CCR_RISE_MSB       = 2;
  localparam int unsigned CCR_RISE_LSB       = 1;
  localparam int unsigned CCR_SWEN_MSB       = 1;
  localparam int unsigned CCR_SWEN_LSB       = 0;
  localparam int unsigned CCR_PERF_ONE_MSB   = 1;
  localparam int unsigned CCR_PERF_ONE_LSB   = 0;
  localparam int unsigned CCR_BIT_PERF_TWO   = 0;

  // ==========================================================================
  // Codes
  // ==========================================================================
  typedef enum logic [2:0] {
    CCR_SRC_NORMAL = 3'h0,
    CCR_SRC_ZEROS  = 3'h1,
    CCR_SRC_ONES   = 3'h2,
    CCR_SRC_TOGGLE = 3'h3,
    CCR_SRC_RAMP   = 3'h4,
    CCR_SRC_CUSTOM = 3'h5,
    CCR_SRC_UNUSED6 = 3'h6,
    CCR_SRC_UNUSED7 = 3'h7
  } ccr_source_t;

  localparam logic [1:0]  CCR_SWING_ENABLED = 2'h3;
  localparam logic [5:0]  CCR_SWING_DEFAULT = 6'h00;
  localparam logic [1:0]  CCR_FMT_TWOS      = 2'h2;
  localparam logic [1:0]  CCR_FMT_OFFSET    = 2'h3;
  localparam logic [1:0]  CCR_IF_DDR        = 2'h1;
  localparam logic [1:0]  CCR_IF_PARALLEL   = 2'h3;
  localparam logic [1:0]  CCR_RISE_DEFAULT  = 2'h0;
  localparam logic [13:0] CCR_TOGGLE_WORD   = 14'h1555;
  localparam int unsigned CCR_WIDE_WIDTH    = 14;
  localparam int unsigned CCR_NARROW_WIDTH  = 12;
  localparam logic [1:0]  CCR_NARROW_RAMP_LAST = 2'h3;

  // Serial frame: bit count at which the address is complete and the frame ends.
  localparam logic [4:0]  CCR_ADDR_BITS  = 5'h08;
  localparam logic [4:0]  CCR_FRAME_BITS = 5'h10;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic enableN;
    logic clock;
    logic data;
  } ccr_serial_t;

  typedef struct packed {
    logic [5:0] swingCode;
    logic [1:0] performanceModeOne;
    logic       performanceModeTwo;
    logic [3:0] gainCode;
    logic       diffClockDriverBoost;
    logic       diffDataDriverBoost;
    logic       twosComplement;
    logic       offsetLoopEnable;
    logic       parallelInterface;
    logic [1:0] singleEndedClockDrive;
    logic [1:0] riseEdgeShift;
  } ccr_config_t;

endpackage : ccr_pkg

/* File: src/ccr_register_bank.sv */
// Purpose: Serial-programmed configuration register bank with output test pattern source.
// Assumes: Serial enable, clock and data are synchronous to ref_clk and stable for two ref_clk cycles each phase.
// Notes:   Shared pin shows over-range or, in readback mode, the addressed register MSB first.
//
// Behaviour
// - All registers reset to zero; gain register 50h.
// - Software reset bit restores defaults, then self-clears.
// - Readback bit selects over-range or serial readout.
// - Readback mode blocks writes except register zero.
// - Performance modes change only through serial writes.
// - Swing code selects output swing level.
// - Swing code applies only when swing enabled.
// - Swing enable field: 11 enables, 00 disables.
// - Gain code sets gain in half-dB steps.
// - Test code picks normal, zeros or ones.
// - Toggle code alternates 0101 and 1010 words.
// - Wide variant ramps one code per cycle.
// - Narrow variant ramps every fourth cycle.
// - Custom code outputs word from two registers.
// - Narrow variant drops two lowest custom bits.
// - Drive boost bits for clock and data.
// - Format field: pin, twos complement, offset binary.
// - Offset loop enable bit.
// - Interface field: pin, double rate, parallel.
// - Single-ended clock drive strength field.
// - Rise edge control enable, else default.
// - Rise edge shift applied only when enabled.
`timescale 1ns/10ps

module ccr_register_bank #(
  parameter int unsigned DATA_WIDTH = 14
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire ccr_pkg::ccr_serial_t  serialIn,
  input  wire logic [DATA_WIDTH-1:0] sampleData,
  input  wire logic                  overRange,
  input  wire logic                  formatSelectPin,
  input  wire logic                  interfaceSelectPin,
  output logic                       overrangeOrReadbackPin,
  output logic [DATA_WIDTH-1:0]      outputWord,
  output ccr_pkg::ccr_config_t       cfgOut
);
  import ccr_pkg::*;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (DATA_WIDTH != CCR_WIDE_WIDTH && DATA_WIDTH != CCR_NARROW_WIDTH) begin : g_bad_width
    $error("DATA_WIDTH must be 12 or 14.");
  end

  // ==========================================================================
  // Address decode
  // ==========================================================================
  typedef struct packed {
    logic       hit;
    logic [3:0] index;
  } ccr_decode_t;

  function automatic ccr_decode_t decodeAddr(input logic [7:0] addr);
    ccr_decode_t result;
    result = '0;
    for (int i = 0; i < CCR_NUM_REGS; i++) begin
      if (CCR_ADDR_LIST[i] == addr) begin
        result.hit   = 1'b1;
        result.index = 4'(i);
      end
    end
    return result;
  endfunction : decodeAddr

  // ==========================================================================
  // Serial frame capture
  // ==========================================================================
  logic              sclkPrev;
  logic [4:0]        bitCount;
  logic [14:0]       shiftIn;
  logic              sclkRise;
  logic              frameActive;
  logic [7:0]        readAddr;
  logic [7:0]        writeAddr;
  logic [7:0]        writeData;
  logic              addrDone;
  logic              frameDone;
  logic [7:0]        regs [CCR_NUM_REGS];
  logic              readbackMode;
  ccr_decode_t       readDecode;
  ccr_decode_t       writeDecode;

  assign sclkRise    = serialIn.clock && !sclkPrev;
  assign frameActive = !serialIn.enableN;
  assign readAddr    = {shiftIn[6:0], serialIn.data};
  assign writeAddr   = shiftIn[14:7];
  assign writeData   = {shiftIn[6:0], serialIn.data};
  assign addrDone    = frameActive && sclkRise && (bitCount == CCR_ADDR_BITS - 5'h01);
  assign frameDone   = frameActive && sclkRise && (bitCount == CCR_FRAME_BITS - 5'h01);
  assign readDecode  = decodeAddr(readAddr);
  assign writeDecode = decodeAddr(writeAddr);
  assign readbackMode = regs[CCR_IDX_CTRL][CCR_BIT_READBACK];

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sclkPrev <= 1'b0;
    end else begin
      sclkPrev <= serialIn.clock;
    end
  end

  // Edges past the sixteenth are ignored until the enable rises again.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bitCount <= 5'h00;
      shiftIn  <= 15'h0000;
    end else if (!frameActive) begin
      bitCount <= 5'h00;
    end else if (sclkRise && bitCount != CCR_FRAME_BITS) begin
      bitCount <= bitCount + 5'h01;
      shiftIn  <= {shiftIn[13:0], serialIn.data};
    end
  end

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic writeAllowed;
  logic softReset;

  assign writeAllowed = frameDone && writeDecode.hit &&
                        (!readbackMode || writeAddr == CCR_ADDR_CTRL);
  assign softReset    = writeAllowed && writeAddr == CCR_ADDR_CTRL &&
                        writeData[CCR_BIT_SOFT_RESET];

  // The reset bit itself is never stored, so it always reads back as zero.
  always_ff @(posedge ref_clk) begin
    if (!rstn || softReset) begin
      for (int i = 0; i < CCR_NUM_REGS; i++) begin
        regs[i] <= CCR_RESET_LIST[i];
      end
    end else if (writeAllowed) begin
      regs[writeDecode.index] <= writeData & CCR_WMASK_LIST[writeDecode.index];
    end
  end

  // ==========================================================================
  // Readback shifter and shared pin
  // ==========================================================================
  logic [7:0] readShift;

  // Register zero and unmapped addresses read as zero in readback mode.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      readShift <= 8'h00;
    end else if (addrDone) begin
      if (readDecode.hit && readAddr != CCR_ADDR_CTRL) begin
        readShift <= regs[readDecode.index];
      end else begin
        readShift <= 8'h00;
      end
    end else if (frameActive && sclkRise && bitCount >= CCR_ADDR_BITS) begin
      readShift <= {readShift[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      overrangeOrReadbackPin <= 1'b0;
    end else if (readbackMode) begin
      overrangeOrReadbackPin <= addrDone ? (readDecode.hit && readAddr != CCR_ADDR_CTRL &&
                                            regs[readDecode.index][7])
                                         : readShift[7];
    end else begin
      overrangeOrReadbackPin <= overRange;
    end
  end

  // ==========================================================================
  // Decoded configuration
  // ==========================================================================
  logic [7:0] ctlSwing;
  logic [7:0] ctlGain;
  logic [7:0] ctlDrive;
  logic [7:0] ctlFormat;
  logic [7:0] ctlIface;
  logic [7:0] ctlSwingEn;
  logic [1:0] formatField;
  logic [1:0] ifaceField;

  assign ctlSwing    = regs[CCR_IDX_SWING];
  assign ctlGain     = regs[CCR_IDX_GAIN_TEST];
  assign ctlDrive    = regs[CCR_IDX_DRIVE];
  assign ctlFormat   = regs[CCR_IDX_FORMAT];
  assign ctlIface    = regs[CCR_IDX_IFACE];
  assign ctlSwingEn  = regs[CCR_IDX_SWING_EN];
  assign formatField = ctlFormat[CCR_FMT_MSB:CCR_FMT_LSB];
  assign ifaceField  = ctlIface[CCR_IF_MSB:CCR_IF_LSB];

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfgOut <= '0;
    end else begin
      // Reserved enable codes behave as disabled; the default swing is safe for any termination.
      if (ctlSwingEn[CCR_SWEN_MSB:CCR_SWEN_LSB] == CCR_SWING_ENABLED) begin
        cfgOut.swingCode <= ctlSwing[CCR_SWING_MSB:CCR_SWING_LSB];
      end else begin
        cfgOut.swingCode <= CCR_SWING_DEFAULT;
      end
      cfgOut.performanceModeOne <= regs[CCR_IDX_PERF_ONE][CCR_PERF_ONE_MSB:CCR_PERF_ONE_LSB];
      cfgOut.performanceModeTwo <= regs[CCR_IDX_PERF_TWO][CCR_BIT_PERF_TWO];
      cfgOut.gainCode           <= ctlGain[CCR_GAIN_MSB:CCR_GAIN_LSB];
      cfgOut.diffClockDriverBoost <= ctlDrive[CCR_BIT_CLK_BOOST];
      cfgOut.diffDataDriverBoost  <= ctlDrive[CCR_BIT_DATA_BOOST];
      if (formatField == CCR_FMT_TWOS) begin
        cfgOut.twosComplement <= 1'b1;
      end else if (formatField == CCR_FMT_OFFSET) begin
        cfgOut.twosComplement <= 1'b0;
      end else begin
        cfgOut.twosComplement <= formatSelectPin;
      end
      cfgOut.offsetLoopEnable <= ctlFormat[CCR_BIT_OFFSET_EN];
      if (ifaceField == CCR_IF_DDR) begin
        cfgOut.parallelInterface <= 1'b0;
      end else if (ifaceField == CCR_IF_PARALLEL) begin
        cfgOut.parallelInterface <= 1'b1;
      end else begin
        cfgOut.parallelInterface <= interfaceSelectPin;
      end
      cfgOut.singleEndedClockDrive <= ctlIface[CCR_SE_DRIVE_MSB:CCR_SE_DRIVE_LSB];
      if (ctlIface[CCR_BIT_RISE_EN]) begin
        cfgOut.riseEdgeShift <= ctlIface[CCR_RISE_MSB:CCR_RISE_LSB];
      end else begin
        cfgOut.riseEdgeShift <= CCR_RISE_DEFAULT;
      end
    end
  end

  // ==========================================================================
  // Test pattern source
  // ==========================================================================
  ccr_source_t           sourceSel;
  logic                  togglePhase;
  logic [1:0]            rampDiv;
  logic                  rampStep;
  logic [DATA_WIDTH-1:0] rampCount;
  logic [13:0]           customWord;
  logic [DATA_WIDTH-1:0] toggleWord;

  assign sourceSel  = ccr_source_t'(ctlGain[CCR_TEST_MSB:CCR_TEST_LSB]);
  assign customWord = {regs[CCR_IDX_CUST_HIGH][CCR_CUST_HIGH_MSB:0], regs[CCR_IDX_CUST_LOW]};
  assign toggleWord = CCR_TOGGLE_WORD[DATA_WIDTH-1:0];
  // The narrow part steps once every fourth cycle, the wide part every cycle.
  assign rampStep   = (DATA_WIDTH == CCR_WIDE_WIDTH) ? 1'b1
                                                     : (rampDiv == CCR_NARROW_RAMP_LAST);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      togglePhase <= 1'b0;
    end else begin
      togglePhase <= !togglePhase;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rampDiv <= 2'h0;
    end else begin
      rampDiv <= rampDiv + 2'h1;
    end
  end

  // Free-running counter; natural overflow gives the wrap to zero.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rampCount <= '0;
    end else if (rampStep) begin
      rampCount <= rampCount + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      outputWord <= '0;
    end else begin
      unique case (sourceSel)
        CCR_SRC_NORMAL:  outputWord <= sampleData;
        CCR_SRC_ZEROS:   outputWord <= '0;
        CCR_SRC_ONES:    outputWord <= '1;
        CCR_SRC_TOGGLE:  outputWord <= togglePhase ? ~toggleWord : toggleWord;
        CCR_SRC_RAMP:    outputWord <= rampCount;
        CCR_SRC_CUSTOM:  outputWord <= customWord[13 -: DATA_WIDTH];
        CCR_SRC_UNUSED6: outputWord <= sampleData;
        CCR_SRC_UNUSED7: outputWord <= sampleData;
      endcase
    end
  end

endmodule : ccr_register_bank

/* File: sim/ccr_register_bank_monitor.sv */
// Purpose: Port-level checker for the configuration register bank.
// Assumes: Frames are decoded here from the serial pins, one write per frame.
// Notes:   Only the fields that gate outputs are mirrored.
`timescale 1ns/10ps

module ccr_register_bank_monitor #(
  parameter int unsigned DATA_WIDTH = 14
) (
  input wire logic                  ref_clk,
  input wire logic                  rstn,
  input wire ccr_pkg::ccr_serial_t  serialIn,
  input wire logic                  overRange,
  input wire logic                  overrangeOrReadbackPin,
  input wire logic [DATA_WIDTH-1:0] outputWord,
  input wire ccr_pkg::ccr_config_t  cfgOut
);
  import ccr_pkg::*;
  localparam logic [DATA_WIDTH-1:0] TOG = CCR_TOGGLE_WORD[DATA_WIDTH-1:0];
  ccr_config_t cfg;
  logic        prevClk, doneQ, readMode, riseEn;
  logic [4:0]  bitCnt;
  logic [15:0] frame;
  logic [1:0]  swEn;
  logic [2:0]  testSel;
  wire         serRise = !serialIn.enableN && serialIn.clock && !prevClk;
  wire         wrOk = doneQ && (frame[15:8] == CCR_ADDR_CTRL || !readMode);
  assign cfg = cfgOut;

  // ==========================================================================
  // Frame decode
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    prevClk <= serialIn.clock;
    doneQ   <= rstn && serRise && bitCnt == 5'h0F;
    if (!rstn || serialIn.enableN) begin
      bitCnt <= 5'h00;
    end else if (serRise && bitCnt < CCR_FRAME_BITS) begin
      bitCnt <= bitCnt + 5'h01;
      frame  <= {frame[14:0], serialIn.data};
    end
  end

  // A soft reset also drops readback, so it shares the reset branch.
  always_ff @(posedge ref_clk) begin
    if (!rstn || (wrOk && frame[15:8] == CCR_ADDR_CTRL && frame[1])) begin
      {readMode, swEn, riseEn, testSel} <= 7'h00;
    end else if (wrOk) begin
      if (frame[15:8] == CCR_ADDR_CTRL) readMode <= frame[0];
      if (frame[15:8] == CCR_ADDR_SWING_EN) swEn <= frame[1:0];
      if (frame[15:8] == CCR_ADDR_IFACE) riseEn <= frame[3];
      if (frame[15:8] == CCR_ADDR_GAIN_TEST) testSel <= frame[2:0];
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_reset_clears: assert property ($rose(rstn) |-> outputWord == '0 && cfg == '0 && !overrangeOrReadbackPin)
    else $error("outputs not cleared by reset");
  a_pin_overrange: assert property ((!readMode)[*3] |-> overrangeOrReadbackPin == $past(overRange))
    else $error("pin does not follow over-range");
  a_readback_lock: assert property (readMode[*4]
    |-> $stable({cfg.gainCode, cfg.swingCode, cfg.diffClockDriverBoost, cfg.diffDataDriverBoost}))
    else $error("configuration changed in readback mode");
  a_perf_serial: assert property ($changed({cfg.performanceModeOne, cfg.performanceModeTwo}) |-> !$past(serialIn.enableN))
    else $error("performance mode changed outside a frame");
  a_swing_gated: assert property ((swEn != CCR_SWING_ENABLED)[*3] |-> cfg.swingCode == CCR_SWING_DEFAULT)
    else $error("swing code used while disabled");
  a_rise_gated: assert property ((!riseEn)[*3] |-> cfg.riseEdgeShift == CCR_RISE_DEFAULT)
    else $error("rise shift used while disabled");
  a_ramp_step: assert property ((DATA_WIDTH == 14 && testSel == CCR_SRC_RAMP)[*3]
    |-> outputWord == DATA_WIDTH'($past(outputWord) + 1'b1)) else $error("ramp did not step by one");
  a_ramp_slow: assert property ((DATA_WIDTH == 12 && testSel == CCR_SRC_RAMP)[*5]
    |-> outputWord == DATA_WIDTH'($past(outputWord, 4) + 1'b1)) else $error("slow ramp did not step by one");
  a_toggle_alt: assert property ((testSel == CCR_SRC_TOGGLE)[*3]
    |-> outputWord == ~$past(outputWord) && (outputWord == TOG || outputWord == ~TOG))
    else $error("toggle pattern wrong");

  c_readback: cover property (readMode[*2]);
  c_soft_reset: cover property (wrOk && frame[15:8] == CCR_ADDR_CTRL && frame[1]);
  c_ramp_wrap: cover property (testSel == CCR_SRC_RAMP && outputWord == '0 && $past(outputWord) != '0);
endmodule : ccr_register_bank_monitor

bind ccr_register_bank ccr_register_bank_monitor #(.DATA_WIDTH(DATA_WIDTH)) i_monitor (
  .ref_clk(ref_clk), .rstn(rstn), .serialIn(serialIn), .overRange(overRange),
  .overrangeOrReadbackPin(overrangeOrReadbackPin), .outputWord(outputWord), .cfgOut(cfgOut));

/* File: sim/ccr_serial_host.sv */
// Purpose: Behavioural serial controller that writes and reads the register bank.
// Assumes: Called from the bench just after a rising ref_clk edge.
// Notes:   holdCyc sets each serial clock phase; larger values model a slow host.
`timescale 1ns/10ps

module ccr_serial_host (
  input  wire logic            ref_clk,
  input  wire logic            readbackPin,
  output ccr_pkg::ccr_serial_t serialIn
);
  import ccr_pkg::*;
  int unsigned holdCyc = 2;
  initial serialIn = 3'b100;

  task automatic step(input int unsigned n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask : step

  // The serial clock idles low and data flips after a frame, so a stale level is never useful.
  task automatic xfer(input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rd);
    logic [15:0] word;
    word = {addr, data};
    rd = 8'h00;
    serialIn.enableN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serialIn.data = word[i];
      step(holdCyc);
      serialIn.clock = 1'b1;
      step(holdCyc);
      serialIn.clock = 1'b0;
      if (i > 0 && i < 9) rd[i-1] = readbackPin;
    end
    step(holdCyc);
    serialIn.enableN = 1'b1;
    serialIn.data = ~serialIn.data;
    step(1);
  endtask : xfer
endmodule : ccr_serial_host

/* File: sim/converter_config_registers_bench.sv */
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: The serial host model carries every register access.
// Notes:   The ramp runs past one wrap so the checker sees it.
`timescale 1ns/10ps

module converter_config_registers_bench;
  import ccr_pkg::*;

  typedef struct packed {
    logic [1:0]  src;
    logic [21:0] val;
  } ccr_note_t;

  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  ccr_serial_t serialIn;
  logic [13:0] sampleData = 14'h0000;
  logic        overRange = 1'b0;
  logic        formatSelectPin = 1'b0;
  logic        interfaceSelectPin = 1'b0;
  logic        pin;
  logic [13:0] outputWord, cust;
  logic [11:0] narrowWord;
  logic [7:0]  rdByte, b;
  ccr_config_t cfgOut, ec;
  ccr_note_t   notes[$];
  ccr_note_t   cur;
  int          miscompares = 0;
  int          nTests = 0;
  int          seed = 62;
  event        probe;

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  ccr_register_bank #(.DATA_WIDTH(14)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .serialIn(serialIn), .sampleData(sampleData), .overRange(overRange),
    .formatSelectPin(formatSelectPin), .interfaceSelectPin(interfaceSelectPin),
    .overrangeOrReadbackPin(pin), .outputWord(outputWord), .cfgOut(cfgOut));
  ccr_serial_host i_host (.ref_clk(ref_clk), .readbackPin(pin), .serialIn(serialIn));
  ccr_register_bank #(.DATA_WIDTH(12)) i_dut_narrow (
    .ref_clk(ref_clk), .rstn(rstn), .serialIn(serialIn), .sampleData(sampleData[11:0]), .overRange(overRange),
    .formatSelectPin(formatSelectPin), .interfaceSelectPin(interfaceSelectPin),
    .overrangeOrReadbackPin(), .outputWord(narrowWord), .cfgOut());

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask : step

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    i_host.xfer(addr, data, unused);
    step(2);
  endtask : wr

  task automatic note(input logic [1:0] src, input logic [21:0] val);
    notes.push_back('{src, val});
    ->probe;
    step(1);
  endtask : note

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    wr(CCR_ADDR_CTRL, 8'h01);
    i_host.xfer(addr, 8'h00, rdByte);
    wr(CCR_ADDR_CTRL, 8'h00);
    note(2'h1, {14'h0000, exp});
  endtask : rd

  task automatic cmp_data(input logic [13:0] exp, input logic [13:0] act);
    nTests++;
    if (act !== exp) begin
      miscompares++;
      $display("Error at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask : cmp_data

  task automatic cmp_cfg(input logic [21:0] exp, input logic [21:0] act);
    nTests++;
    if (act !== exp) begin
      miscompares++;
      $display("Error at %0t: expected %h, got %h", $time, exp, act);
    end
  endtask : cmp_cfg

  task automatic end_of_test;
    if (miscompares == 0 && nTests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  initial begin
    forever begin
      @probe;
      cur = notes.pop_front();
      if (cur.src == 2'h2) begin
        cmp_cfg(cur.val, cfgOut);
      end else begin
        cmp_data(cur.val[13:0], cur.src == 2'h1 ? {6'h00, rdByte} :
                                cur.src == 2'h3 ? {2'h0, narrowWord} : outputWord);
      end
    end
  end

  always begin
    step(1);
    overRange = 1'($random(seed));
  end

  initial begin
    #(100 * 40000);
    miscompares++;
    end_of_test();
  end

  initial begin
    ec = '0;
    ec.gainCode = 4'h5;
    step(8);
    rstn = 1'b1;
    step(2);
    note(2'h2, ec);
    rd(CCR_ADDR_GAIN_TEST, 8'h50);
    rd(CCR_ADDR_CTRL, 8'h00);
    wr(CCR_ADDR_CTRL, 8'h01);
    wr(CCR_ADDR_DRIVE, 8'h03);
    note(2'h2, ec);
    wr(CCR_ADDR_CTRL, 8'h00);
    wr(CCR_ADDR_DRIVE, 8'h03);
    {ec.diffClockDriverBoost, ec.diffDataDriverBoost} = 2'h3;
    note(2'h2, ec);
    wr(CCR_ADDR_SWING, 8'hF8);
    note(2'h2, ec);
    wr(CCR_ADDR_SWING_EN, 8'h03);
    ec.swingCode = 6'h3E;
    note(2'h2, ec);
    i_host.holdCyc = 3;
    wr(CCR_ADDR_PERF_ONE, 8'h03);
    wr(CCR_ADDR_PERF_TWO, 8'h01);
    {ec.performanceModeOne, ec.performanceModeTwo} = 3'h7;
    note(2'h2, ec);
    i_host.holdCyc = 2;
    for (int i = 0; i < 8; i++) begin
      b = 8'($random(seed));
      {formatSelectPin, interfaceSelectPin} = b[1:0];
      wr(CCR_ADDR_FORMAT, {i[1:0], 6'h20});
      wr(CCR_ADDR_IFACE, {i[2:1], b[7:3], 1'b0});
      ec.twosComplement = i[1] ? ~i[0] : b[1];
      ec.offsetLoopEnable = 1'b1;
      ec.parallelInterface = i[1] ? i[2] : b[0];
      ec.singleEndedClockDrive = b[7:6];
      ec.riseEdgeShift = b[5] ? b[4:3] : 2'h0;
      note(2'h2, ec);
    end
    cust = 14'($random(seed));
    sampleData = 14'($random(seed));
    wr(CCR_ADDR_CUST_HIGH, {2'h0, cust[13:8]});
    wr(CCR_ADDR_CUST_LOW, cust[7:0]);
    for (int i = 0; i < 7; i++) begin
      wr(CCR_ADDR_GAIN_TEST, {4'(5 + i), 1'b0, 3'(i)});
      ec.gainCode = 4'(5 + i);
      note(2'h2, ec);
      case (i)
        0, 6: note(2'h0, {8'h00, sampleData});
        1: note(2'h0, 22'h0);
        2: note(2'h0, 22'h3FFF);
        5: begin
          note(2'h0, {8'h00, cust});
          note(2'h3, {10'h000, cust[13:2]});
        end
        default: step(20);
      endcase
    end
    wr(CCR_ADDR_GAIN_TEST, 8'hC4);
    ec.gainCode = 4'hC;
    note(2'h2, ec);
    step(16500);
    wr(CCR_ADDR_CTRL, 8'h03);
    ec = '0;
    ec.gainCode = 4'h5;
    {ec.twosComplement, ec.parallelInterface} = {formatSelectPin, interfaceSelectPin};
    note(2'h2, ec);
    wr(CCR_ADDR_PERF_ONE, 8'h03);
    rstn = 1'b0;
    step(8);
    rstn = 1'b1;
    step(2);
    note(2'h2, ec);
    end_of_test();
  end
endmodule : converter_config_registers_bench
